// *** hdl/sts_top.sv ***
// Timer count, watchdog and shared scaler with a Wishbone register port
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`include "sts_defs.svh"

module sts_top #(
    parameter int WDT_BASE_CYCLES = `STS_WDT_BASE_US * `STS_CLK_MHZ
) (
    input wire logic sys_clk, // System clock, 50 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic ce, // Clock enable, freezes all state when low
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Bus strobe
    input wire logic wb_we_i, // Write
    input wire logic [11:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte enables
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    input wire logic timer_ext_clk, // External timer clock pin
    output logic irq_o, // Level interrupt
    output logic wdt_timeout_o // Watchdog expiry pulse
);
    sts_pkg::sts_byte_t tmr_ff, nxt_tmr;
    sts_pkg::sts_byte_t int_ff, nxt_int;
    sts_pkg::sts_byte_t cfg_ff, nxt_cfg;
    sts_pkg::sts_byte_t mask_ff, nxt_mask;
    logic wen_ff, nxt_wen;
    logic [1:0] stat_ff, nxt_stat;
    logic ack_ff, nxt_ack;
    logic [31:0] dat_ff, nxt_dat;
    logic irq_ff, nxt_irq;
    logic wto_ff, nxt_wto;
    logic ext_d_ff;
    logic req, wr;
    logic [7:0] idx;
    logic adr_ok;
    logic wr_tmr, wr_int, wr_cfg, wr_stat, wr_mask, wr_wctl;
    logic [7:0] rd_val;
    sts_pkg::sts_byte_t wdata;
    sts_pkg::sts_owner_e owner;
    logic src_ev, tmr_inc, tov;
    logic wdt_clr, wdt_base_tick, wdt_expire;
    logic scl_inc, scl_clr, scl_tick;
    logic [7:0] scl_cnt;

    assign wb_dat_o = dat_ff;
    assign wb_ack_o = ack_ff;
    assign irq_o = irq_ff;
    assign wdt_timeout_o = wto_ff;

    // Request decode; a write commits on the edge that samples ack
    assign req = wb_cyc_i && wb_stb_i;
    assign wr = req && ack_ff && wb_we_i && wb_sel_i[0];
    assign idx = wb_adr_i[9:2];
    assign adr_ok = (wb_adr_i[11:10] == 2'b00);
    assign wdata = wb_dat_i[7:0];

    // Register select and read mux; scaler count has no slot here
    always_comb begin
        wr_tmr = 1'b0;
        wr_int = 1'b0;
        wr_cfg = 1'b0;
        wr_stat = 1'b0;
        wr_mask = 1'b0;
        wr_wctl = 1'b0;
        rd_val = 8'h00;
        if (!adr_ok) begin
            rd_val = 8'h00;
        end else if (idx == `STS_IDX_TMR) begin
            wr_tmr = wr;
            rd_val = tmr_ff;
        end else if (idx == `STS_IDX_INT) begin
            wr_int = wr;
            rd_val = int_ff;
        end else if (idx == `STS_IDX_CFG) begin
            wr_cfg = wr;
            rd_val = cfg_ff;
        end else if (idx == `STS_IDX_STAT) begin
            wr_stat = wr;
            rd_val = {6'h00, stat_ff};
        end else if (idx == `STS_IDX_MASK) begin
            wr_mask = wr;
            rd_val = mask_ff;
        end else if (idx == `STS_IDX_WCTL) begin
            wr_wctl = wr;
            rd_val = {7'h00, wen_ff};
        end
    end

    // Bus answer one cycle after the request; unmapped reads give zero
    always_comb begin
        nxt_ack = req && !ack_ff;
        nxt_dat = dat_ff;
        if (req && !ack_ff) begin
            nxt_dat = {24'h000000, rd_val};
        end
    end

    // Owner from the assignment bit; both users keep running on a change
    assign owner = cfg_ff[`STS_CFG_OWN] ? sts_pkg::STS_OWN_WDT : sts_pkg::STS_OWN_TIMER;

    // Timer source: every cycle, or chosen edge of the pin
    always_comb begin
        src_ev = 1'b1;
        if (cfg_ff[`STS_CFG_TCS]) begin
            if (cfg_ff[`STS_CFG_TSE]) begin
                src_ev = ext_d_ff && !timer_ext_clk;
            end else begin
                src_ev = !ext_d_ff && timer_ext_clk;
            end
        end
    end

    assign wdt_clr = wr_wctl && wdata[`STS_WC_CLR];

    // Scaler routing; the non-owner bypasses it
    always_comb begin
        if (owner == sts_pkg::STS_OWN_TIMER) begin
            scl_inc = src_ev;
            scl_clr = wr_tmr;
            tmr_inc = scl_tick;
            wdt_expire = wdt_base_tick;
        end else begin
            scl_inc = wdt_base_tick;
            scl_clr = wdt_clr;
            tmr_inc = src_ev;
            wdt_expire = scl_tick;
        end
    end

    sts_scaler #(
        .W(8)
    ) u_scl (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .clr(scl_clr),
        .inc(scl_inc),
        .ratio(cfg_ff[`STS_CFG_PS_LSB +: 3]),
        .shift(owner == sts_pkg::STS_OWN_TIMER),
        .tick(scl_tick),
        .cnt(scl_cnt)
    );

    sts_wdt #(
        .BASE_CYCLES(WDT_BASE_CYCLES)
    ) u_wdt (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .en(wen_ff),
        .clr(wdt_clr),
        .base_tick(wdt_base_tick)
    );

    // Timer count; a write wins over the increment in the same cycle
    assign tov = tmr_inc && !wr_tmr && (tmr_ff == 8'hff);
    always_comb begin
        nxt_tmr = tmr_ff;
        if (wr_tmr) begin
            nxt_tmr = wdata;
        end else if (tmr_inc) begin
            nxt_tmr = tmr_ff + 8'h01;
        end
    end

    // Control registers; overflow flag set wins over a software clear
    always_comb begin
        nxt_int = wr_int ? wdata : int_ff;
        nxt_int[`STS_INT_TOV] = nxt_int[`STS_INT_TOV] | tov;
        nxt_cfg = wr_cfg ? wdata : cfg_ff;
        nxt_mask = wr_mask ? wdata : mask_ff;
        nxt_wen = wr_wctl ? wdata[`STS_WC_EN] : wen_ff;
    end

    // Sticky status, write one to clear; a new event wins
    always_comb begin
        nxt_stat = stat_ff;
        if (wr_stat) begin
            nxt_stat = stat_ff & ~wdata[1:0];
        end
        nxt_stat[`STS_ST_TOV] = nxt_stat[`STS_ST_TOV] | tov;
        nxt_stat[`STS_ST_WTO] = nxt_stat[`STS_ST_WTO] | wdt_expire;
        nxt_irq = |(stat_ff & mask_ff[1:0]);
        nxt_wto = wdt_expire;
    end

    // Register file and output flops
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tmr_ff <= `STS_TMR_RST;
            int_ff <= `STS_INT_RST;
            cfg_ff <= `STS_CFG_RST;
            mask_ff <= `STS_MASK_RST;
            wen_ff <= 1'(`STS_WCTL_RST);
            stat_ff <= `STS_STAT_RST;
            ack_ff <= 1'b0;
            dat_ff <= 32'h00000000;
            irq_ff <= 1'b0;
            wto_ff <= 1'b0;
            ext_d_ff <= 1'b0;
        end else if (ce) begin
            tmr_ff <= nxt_tmr;
            int_ff <= nxt_int;
            cfg_ff <= nxt_cfg;
            mask_ff <= nxt_mask;
            wen_ff <= nxt_wen;
            stat_ff <= nxt_stat;
            ack_ff <= nxt_ack;
            dat_ff <= nxt_dat;
            irq_ff <= nxt_irq;
            wto_ff <= nxt_wto;
            ext_d_ff <= timer_ext_clk;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_timer_write;
        ce && wr_tmr && owner == sts_pkg::STS_OWN_TIMER;
    endsequence

    sequence s_scaler_zero;
        scl_cnt == 8'h00;
    endsequence

    property p_tmr_wr_clears;
        s_timer_write |=> s_scaler_zero;
    endproperty
    a_tmr_wr_clears: assert property (p_tmr_wr_clears) else $error("scaler kept count");

    property p_wdt_clr_clears;
        ce && wdt_clr && owner == sts_pkg::STS_OWN_WDT |=> s_scaler_zero ##1 !wto_ff;
    endproperty
    a_wdt_clr_clears: assert property (p_wdt_clr_clears) else $error("clear missed");

    property p_wdt_unscaled;
        ce && owner == sts_pkg::STS_OWN_TIMER |=> wto_ff == $past(wdt_base_tick);
    endproperty
    a_wdt_unscaled: assert property (p_wdt_unscaled) else $error("watchdog scaled");

    property p_tmr_unscaled;
        ce && owner == sts_pkg::STS_OWN_WDT && src_ev && !wr_tmr
            |=> tmr_ff == 8'($past(tmr_ff) + 8'h01);
    endproperty
    a_tmr_unscaled: assert property (p_tmr_unscaled) else $error("timer scaled");

    property p_cfg_owner;
        ce && wr_cfg |=> owner == ($past(wdata[`STS_CFG_OWN]) ? sts_pkg::STS_OWN_WDT
            : sts_pkg::STS_OWN_TIMER);
    endproperty
    a_cfg_owner: assert property (p_cfg_owner) else $error("owner not updated");

    property p_switch_runs;
        ce && wr_cfg && !wr_tmr |=> tmr_ff == $past(tmr_ff) || tmr_ff == 8'($past(tmr_ff) + 8'h01);
    endproperty
    a_switch_runs: assert property (p_switch_runs) else $error("timer disturbed");

    property p_read_hides;
        ack_ff |-> dat_ff[31:8] == 24'h000000;
    endproperty
    a_read_hides: assert property (p_read_hides) else $error("read data too wide");

    property p_ratio_timer;
        ce && owner == sts_pkg::STS_OWN_TIMER && scl_tick |-> scl_cnt[0] == 1'b1;
    endproperty
    a_ratio_timer: assert property (p_ratio_timer) else $error("timer ratio below 2");

    // A config write must not cost the timer a pending step
    property p_switch_counts;
        ce && wr_cfg && tmr_inc && !wr_tmr |=> tmr_ff == 8'($past(tmr_ff) + 8'h01);
    endproperty
    a_switch_counts: assert property (p_switch_counts) else $error("timer halted");

    property p_expire_flag;
        ce && wdt_expire |=> stat_ff[`STS_ST_WTO] && wto_ff;
    endproperty
    a_expire_flag: assert property (p_expire_flag) else $error("expiry not flagged");

    property p_tov_flags;
        ce && tov |=> stat_ff[`STS_ST_TOV] && int_ff[`STS_INT_TOV];
    endproperty
    a_tov_flags: assert property (p_tov_flags) else $error("overflow not flagged");

    property p_ack_pulse;
        ce && ack_ff |=> !ack_ff;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
endmodule

// *** hdl/sts_defs.svh ***
// Register indices, field positions, reset values and timing counts of the shared scaler
`ifndef STS_DEFS_SVH
`define STS_DEFS_SVH
`define STS_CLK_MHZ 50
`define STS_WDT_BASE_US 18000
`define STS_IDX_TMR 8'h01
`define STS_IDX_INT 8'h0b
`define STS_IDX_CFG 8'h81
`define STS_IDX_STAT 8'h20
`define STS_IDX_MASK 8'h21
`define STS_IDX_WCTL 8'h22
`define STS_CFG_OWN 3
`define STS_CFG_PS_LSB 0
`define STS_CFG_TSE 4
`define STS_CFG_TCS 5
`define STS_INT_TOV 2
`define STS_ST_TOV 0
`define STS_ST_WTO 1
`define STS_WC_EN 0
`define STS_WC_CLR 1
`define STS_CFG_RST 8'hff
`define STS_INT_RST 8'h00
`define STS_TMR_RST 8'h00
`define STS_WCTL_RST 8'h00
`define STS_MASK_RST 8'h00
`define STS_STAT_RST 2'h0
`endif

// *** hdl/sts_pkg.sv ***
// Shared types of the timer and watchdog scaler block
package sts_pkg;
    typedef logic [7:0] sts_byte_t;
    typedef enum logic {STS_OWN_TIMER, STS_OWN_WDT} sts_owner_e;
endpackage

// *** hdl/sts_scaler.sv ***
// Shared 8-bit scaling counter with power-of-two tap select
`timescale 1ns/1ps
`include "sts_defs.svh"
module sts_scaler #(
    parameter int W = 8
) (
    input wire logic sys_clk, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic ce, // Clock enable
    input wire logic clr, // Clear the count
    input wire logic inc, // Count event
    input wire logic [2:0] ratio, // Ratio field
    input wire logic shift, // One extra stage for timer use
    output logic tick, // Scaled event
    output logic [W-1:0] cnt // Current count, not software visible
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic [W-1:0] mask;

    // Tap mask, one stage per bit; 1:1 gives an empty mask
    for (genvar i = 0; i < W; i++) begin : g_mask
        assign mask[i] = (4'(i) < ({1'b0, ratio} + {3'b000, shift}));
    end

    assign tick = inc && !clr && ((cnt_ff & mask) == mask);
    assign cnt = cnt_ff;

    // Free counting keeps every tap exact without a compare
    always_comb begin
        nxt_cnt = cnt_ff;
        if (clr) begin
            nxt_cnt = '0;
        end else if (inc) begin
            nxt_cnt = cnt_ff + 1'b1;
        end
    end

    // Count register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else if (ce) begin
            cnt_ff <= nxt_cnt;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_count_step;
        ce && inc && !clr |=> cnt_ff == W'($past(cnt_ff) + 1'b1);
    endproperty
    a_count_step: assert property (p_count_step) else $error("scaler step wrong");

    property p_tap_wrap;
        ce && tick |=> (cnt_ff & mask) == '0 || $past(mask) != mask;
    endproperty
    a_tap_wrap: assert property (p_tap_wrap) else $error("scaler tick off tap");
endmodule

// *** hdl/sts_wdt.sv ***
// Watchdog base period counter
`timescale 1ns/1ps
`include "sts_defs.svh"
module sts_wdt #(
    parameter int BASE_CYCLES = `STS_WDT_BASE_US * `STS_CLK_MHZ
) (
    input wire logic sys_clk, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic ce, // Clock enable
    input wire logic en, // Watchdog running
    input wire logic clr, // Clear instruction
    output logic base_tick // One base period elapsed
);
    localparam int CW = $clog2(BASE_CYCLES + 1);
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;

    assign base_tick = en && !clr && (cnt_ff == CW'(BASE_CYCLES - 1));

    // Disabled watchdog holds at zero so enabling starts a full period
    always_comb begin
        nxt_cnt = cnt_ff + 1'b1;
        if (clr || !en || base_tick) begin
            nxt_cnt = '0;
        end
    end

    // Period counter
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else if (ce) begin
            cnt_ff <= nxt_cnt;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_clr_base;
        ce && clr |=> cnt_ff == '0 ##1 !base_tick;
    endproperty
    a_clr_base: assert property (p_clr_base) else $error("watchdog not cleared");
endmodule

// *** verif/tb_sts_top.sv ***
// Self-checking bench of the shared timer and watchdog scaler
`timescale 1ns/1ps
`include "sts_defs.svh"
module tb_sts_top;
    localparam int BASE = 20;
    typedef struct {logic we; logic [7:0] idx; logic [7:0] wd; logic [7:0] exp;} sts_row_s;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic pin = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, irq_o, wdt_timeout_o;
    logic [7:0] rd;
    int fails = 0;
    int samples_checked = 0;
    int pulses = 0;
    int cyc_cnt = 0;
    int k;
    sts_row_s rows[14] = '{
        '{0, `STS_IDX_CFG, 8'h00, `STS_CFG_RST}, '{0, `STS_IDX_TMR, 8'h00, `STS_TMR_RST},
        '{0, `STS_IDX_INT, 8'h00, `STS_INT_RST}, '{0, `STS_IDX_STAT, 8'h00, 8'h00},
        '{0, `STS_IDX_MASK, 8'h00, 8'h00}, '{0, `STS_IDX_WCTL, 8'h00, `STS_WCTL_RST},
        '{0, 8'h40, 8'h00, 8'h00}, '{1, `STS_IDX_MASK, 8'h02, 8'h00},
        '{0, `STS_IDX_MASK, 8'h00, 8'h02}, '{1, 8'h40, 8'h5a, 8'h00},
        '{0, 8'h40, 8'h00, 8'h00}, '{1, `STS_IDX_WCTL, 8'h02, 8'h00},
        '{0, `STS_IDX_WCTL, 8'h00, 8'h00}, '{1, `STS_IDX_MASK, 8'h00, 8'h00}};

    sts_top #(.WDT_BASE_CYCLES(BASE)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .timer_ext_clk(pin), .irq_o(irq_o), .wdt_timeout_o(wdt_timeout_o));

    // Free clock, 20 ns period
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    // Expiry pulse count and hang guard
    always @(posedge sys_clk) begin
        cyc_cnt++;
        if (wdt_timeout_o === 1'b1) pulses++;
        if (cyc_cnt == 30000) begin
            fails++;
            give_verdict();
        end
    end

    // One classic cycle; waits for ack, never assumes its latency
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      input logic [3:0] s);
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {2'b00, idx, 2'b00};
        sel <= s;
        dat <= {24'h000000, d};
        do begin
            @(posedge sys_clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [7:0] got, input int lo, input int hi, input string m);
        samples_checked++;
        if ($isunknown(got) || got < lo || got > hi) begin
            fails++;
            $display("mismatch at %0t: %s got %0d want %0d..%0d", $time, m, got, lo, hi);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watch expiry count over a window, owner and ratio already set
    task automatic watch(input int win, input int lo, input int hi, input string m);
        pulses = 0;
        repeat (win) @(posedge sys_clk);
        chk_rng(pulses[7:0], lo, hi, m);
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        // Reset values and plain accesses, unmapped place included
        foreach (rows[i]) begin
            wb(rows[i].we, rows[i].idx, rows[i].wd, 4'hf);
            if (!rows[i].we) chk(rd, rows[i].exp, "table read");
        end
        wb(1, `STS_IDX_MASK, 8'h03, 4'he);
        wb(0, `STS_IDX_MASK, 8'h00, 4'hf);
        chk(rd, 8'h00, "sel0 low write");
        $display("test table done");
        // Every timer ratio; timer write clears the scaler first
        for (int ps = 0; ps < 8; ps++) begin
            wb(1, `STS_IDX_CFG, ps[7:0], 4'hf);
            wb(1, `STS_IDX_TMR, 8'h00, 4'hf);
            k = 4 * (2 << ps) + ps;
            repeat (k) @(posedge sys_clk);
            wb(0, `STS_IDX_TMR, 8'h00, 4'hf);
            chk_rng(rd, (k - 1) / (2 << ps), (k + 2) / (2 << ps), "timer ratio");
        end
        $display("test timer ratios done");
        // Timer owner: repeated writes keep the count at zero
        wb(1, `STS_IDX_CFG, 8'h07, 4'hf);
        repeat (4) begin
            wb(1, `STS_IDX_TMR, 8'h00, 4'hf);
            repeat (150) @(posedge sys_clk);
            wb(0, `STS_IDX_TMR, 8'h00, 4'hf);
            chk(rd, 8'h00, "timer write clears scaler");
        end
        // Timer owns the scaler: watchdog unscaled
        wb(1, `STS_IDX_WCTL, 8'h03, 4'hf);
        watch(400, 19, 21, "watchdog unscaled");
        // Hand over to the watchdog in the safe order, ratio 1:4
        wb(1, `STS_IDX_TMR, 8'h00, 4'hf);
        wb(1, `STS_IDX_WCTL, 8'h03, 4'hf);
        wb(1, `STS_IDX_CFG, 8'h0a, 4'hf);
        watch(400, 4, 6, "watchdog postscaled");
        // Clear command often enough holds expiry off
        wb(1, `STS_IDX_CFG, 8'h0b, 4'hf);
        wb(1, `STS_IDX_WCTL, 8'h03, 4'hf);
        // Let a pulse from before the clear drain before counting
        repeat (2) @(posedge sys_clk);
        pulses = 0;
        repeat (8) begin
            wb(1, `STS_IDX_WCTL, 8'h03, 4'hf);
            repeat (60) @(posedge sys_clk);
        end
        chk(pulses[7:0], 8'h00, "clear command");
        // Watchdog owns the scaler: timer unscaled
        wb(1, `STS_IDX_TMR, 8'h00, 4'hf);
        repeat (40) @(posedge sys_clk);
        wb(0, `STS_IDX_TMR, 8'h00, 4'hf);
        chk_rng(rd, 39, 42, "timer unscaled");
        // Hand back to the timer: clear watchdog and scaler, then 1:2
        wb(1, `STS_IDX_WCTL, 8'h03, 4'hf);
        wb(1, `STS_IDX_CFG, 8'h00, 4'hf);
        wb(1, `STS_IDX_TMR, 8'h00, 4'hf);
        repeat (40) @(posedge sys_clk);
        wb(0, `STS_IDX_TMR, 8'h00, 4'hf);
        chk_rng(rd, 20, 21, "timer prescaled after hand back");
        wb(1, `STS_IDX_CFG, 8'h08, 4'hf);
        $display("test assignment done");
        // Overflow flags and masked level interrupt
        wb(1, `STS_IDX_WCTL, 8'h00, 4'hf);
        wb(1, `STS_IDX_STAT, 8'h03, 4'hf);
        wb(1, `STS_IDX_INT, 8'h00, 4'hf);
        wb(1, `STS_IDX_TMR, 8'hf8, 4'hf);
        repeat (20) @(posedge sys_clk);
        wb(0, `STS_IDX_STAT, 8'h00, 4'hf);
        chk(rd & 8'h01, 8'h01, "overflow status");
        wb(0, `STS_IDX_INT, 8'h00, 4'hf);
        chk(rd & 8'h04, 8'h04, "overflow flag");
        chk({7'h00, irq_o}, 8'h00, "irq masked");
        wb(1, `STS_IDX_MASK, 8'h01, 4'hf);
        repeat (2) @(posedge sys_clk);
        chk({7'h00, irq_o}, 8'h01, "irq raised");
        wb(1, `STS_IDX_STAT, 8'h01, 4'hf);
        repeat (2) @(posedge sys_clk);
        chk({7'h00, irq_o}, 8'h00, "irq cleared");
        $display("test interrupt done");
        // Clock enable low freezes the timer; ten steps after it rises
        wb(1, `STS_IDX_TMR, 8'h00, 4'hf);
        ce <= 1'b0;
        repeat (30) @(posedge sys_clk);
        ce <= 1'b1;
        repeat (9) @(posedge sys_clk);
        wb(0, `STS_IDX_TMR, 8'h00, 4'hf);
        chk(rd, 8'h0a, "clock enable freeze");
        $display("test clock enable done");
        // External pin source, rising then falling edge
        for (int f = 0; f < 2; f++) begin
            wb(1, `STS_IDX_CFG, f ? 8'h38 : 8'h28, 4'hf);
            wb(1, `STS_IDX_TMR, 8'h00, 4'hf);
            repeat (6 + 4 * f) begin
                @(posedge sys_clk) pin <= 1'b1;
                repeat (3) @(posedge sys_clk);
                pin <= 1'b0;
                repeat (3) @(posedge sys_clk);
            end
            wb(0, `STS_IDX_TMR, 8'h00, 4'hf);
            chk(rd, 8'(6 + 4 * f), "pin edges");
        end
        $display("test pin source done");
        // Second reset in mid-run restores the reset values
        wb(1, `STS_IDX_CFG, 8'h00, 4'hf);
        @(posedge sys_clk) rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        wb(0, `STS_IDX_CFG, 8'h00, 4'hf);
        chk(rd, `STS_CFG_RST, "config after reset");
        wb(0, `STS_IDX_MASK, 8'h00, 4'hf);
        chk(rd, 8'h00, "mask after reset");
        $display("test second reset done");
        give_verdict();
    end
endmodule
